//--- hdl/bdcs_bank.sv
// control word, over-current status word and stage drive logic
//
// Contract
// - control bits 1..17 switch stages
// - modulation enable gates stage by input
// - never both legs of bridge on
// - test mode routes signal onto data out
// - over-current sets flag, disables stage
// - enabled recovery pulses stage at duty
// - bit 0 is NOR of all flags
// - one recovery cycle may occur anyway
`timescale 1ns/100ps
module bdcs_bank
    import bdcs_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // control word write (frame latched at chip select rise)
    input wire logic ctrl_wr_in,
    input wire logic [23:0] ctrl_word_in,
    // per-stage modulation enable and input selection (from second word)
    input wire logic [16:0] mod_en_in,
    input wire logic [16:0] mod_sel_b_in,
    input wire logic modulation_input_a_in,
    input wire logic modulation_input_b_in,
    // per-stage recovery enable and over-current events
    input wire logic [16:0] rec_en_in,
    input wire logic [16:0] oc_event_in,
    // flags of the second status word, bits 1..22
    input wire logic [21:0] status1_flags_in,
    // test mode and internal signal sources
    input wire logic test_mode_in,
    input wire logic [7:0] test_sig_in,
    input wire logic serial_data_in,
    // stage drive and status
    output logic [16:0] stage_on_out,
    output logic [23:0] status_word_out,
    output logic serial_data_out
);
    bdcs_state_t s_r, s_nxt;
    logic [16:0] cmd;
    logic [16:0] gated;
    logic [16:0] want;
    logic rec_on;

    // stage commands from control bits
    always_comb begin
        cmd = s_r.ctrl[BDCS_STAGE_LSB +: BDCS_STAGES];
    end

    // per-stage gating by modulation input
    genvar g;
    generate
        for (g = 0; g < BDCS_STAGES; g++) begin : g_stage
            assign gated[g] = cmd[g] & (~mod_en_in[g] |
                (mod_sel_b_in[g] ? modulation_input_b_in : modulation_input_a_in));
        end
    endgenerate

    // recovery phase: on during the first duty share of each period
    always_comb begin
        rec_on = s_r.rec_cnt < (s_r.ctrl[BDCS_DUTY_BIT] ? BDCS_REC_ON_25 : BDCS_REC_ON_12);
    end

    // next state
    always_comb begin
        s_nxt = s_r;
        if (ctrl_wr_in) begin
            s_nxt.ctrl = ctrl_word_in;
        end
        s_nxt.rec_cnt = (s_r.rec_cnt == BDCS_REC_PERIOD - 8'h01) ? 8'h00 : s_r.rec_cnt + 8'h01;
        // reset bit clears flags; new events still win
        if (ctrl_wr_in && ctrl_word_in[BDCS_RESET_BIT]) begin
            s_nxt.flag = BDCS_FLAG_RST;
            s_nxt.rec_act = BDCS_FLAG_RST;
        end
        // event sets flag at its stage
        s_nxt.flag = s_nxt.flag | oc_event_in;
        // a tripped stage runs at least the current recovery cycle
        s_nxt.rec_act = s_nxt.rec_act | oc_event_in;
        // recovery permission is only re-read at the period boundary
        if (s_r.rec_cnt == BDCS_REC_PERIOD - 8'h01) begin
            s_nxt.rec_act = (s_nxt.rec_act & rec_en_in) | oc_event_in;
        end
        // flagged stage off unless recovering; cleared stage follows command
        want = gated & (~s_nxt.flag | (s_nxt.rec_act & {17{rec_on}}));
        want = want & ~oc_event_in;
        // bridge interlock, both requested means both off
        for (int b = 0; b < BDCS_BRIDGES; b++) begin
            if (want[2*b] && want[2*b+1]) begin
                want[2*b] = 1'b0;
                want[2*b+1] = 1'b0;
            end
        end
        s_nxt.drive = want;
        s_nxt.noerr = ~(|s_nxt.flag | |status1_flags_in);
    end

    // state register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_r <= '{ctrl: BDCS_CTRL_RST, flag: BDCS_FLAG_RST, rec_act: BDCS_FLAG_RST,
                     rec_cnt: 8'h00, drive: BDCS_FLAG_RST, noerr: 1'b1};
        end else if (clk_en_in) begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign stage_on_out = s_r.drive;
    assign status_word_out = {6'h00, s_r.flag, s_r.noerr};
    // test mux on data out, selected by low control bits
    assign serial_data_out = test_mode_in ? test_sig_in[s_r.ctrl[3:1]] : serial_data_in;


    // ------------------------------------------------------------------
    // checks on the drive side
    // ------------------------------------------------------------------

    AST_INTERLOCK: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !(stage_on_out[0] && stage_on_out[1]) &&
        !(stage_on_out[2] && stage_on_out[3]) &&
        !(stage_on_out[4] && stage_on_out[5]) &&
        !(stage_on_out[6] && stage_on_out[7]) &&
        !(stage_on_out[8] && stage_on_out[9]) &&
        !(stage_on_out[10] && stage_on_out[11]))
        else $error("both legs of a bridge on");

    AST_BOTH_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && cmd[2] && cmd[3] |=> !stage_on_out[2] && !stage_on_out[3])
        else $error("bridge leg on while both requested");

    AST_CMD_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && !cmd[7] |=> !stage_on_out[7])
        else $error("stage on without command");

    AST_CMD_ON: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && cmd[16] && !mod_en_in[16] && !s_r.flag[16] && !oc_event_in[16] |=> stage_on_out[16])
        else $error("commanded stage not driven");

    AST_MOD_GATE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && mod_en_in[8] && !mod_sel_b_in[8] && !modulation_input_a_in |=> !stage_on_out[8])
        else $error("stage on while modulation low");

    // frozen enable holds the stage and status outputs
    AST_FREEZE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !clk_en_in |=> $stable(stage_on_out) && $stable(status_word_out))
        else $error("state moved while clock enable low");

    // ------------------------------------------------------------------
    // checks on the status side
    // ------------------------------------------------------------------

    AST_NOERR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && |oc_event_in |=> !status_word_out[0])
        else $error("no-error bit set after event");

    AST_NOERR_FLAGS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        status_word_out[0] |-> status_word_out[17:1] == 17'h00000)
        else $error("no-error bit set beside a flag");

    AST_UPPER_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        status_word_out[23:18] == 6'h00)
        else $error("unused status bits not zero");

    AST_FLAG_SET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && oc_event_in[4] |=> status_word_out[5] && !stage_on_out[4])
        else $error("flag not set or stage still on");

    AST_FLAG_STICKY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && s_r.flag[1] && !(ctrl_wr_in && ctrl_word_in[BDCS_RESET_BIT]) |=> status_word_out[2])
        else $error("flag dropped without clear");

    AST_RESET_CLR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && ctrl_wr_in && ctrl_word_in[BDCS_RESET_BIT] && !oc_event_in[2] |=> !status_word_out[3])
        else $error("flag not cleared by reset bit");

    // ------------------------------------------------------------------
    // checks on recovery and test routing
    // ------------------------------------------------------------------

    AST_FLAG_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clk_en_in && s_r.flag[12] && !rec_en_in[12] && !s_r.rec_act[12] &&
        !(ctrl_wr_in && ctrl_word_in[BDCS_RESET_BIT]) |=> !stage_on_out[12])
        else $error("latched stage driven");

    AST_REC_DUTY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        s_r.flag[6] && !rec_on && !(ctrl_wr_in && ctrl_word_in[BDCS_RESET_BIT]) |->
        !s_nxt.drive[6] || oc_event_in[6])
        else $error("recovering stage on outside duty");

    AST_TESTMUX: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !test_mode_in |-> serial_data_out == serial_data_in)
        else $error("data out wrong outside test mode");

    // main scenarios reached
    COV_TRIP: cover property (@(posedge sys_clk_in) oc_event_in[0]);
    COV_REC: cover property (@(posedge sys_clk_in) s_r.flag[14] && stage_on_out[14]);
    COV_CLEAR: cover property (@(posedge sys_clk_in) ctrl_wr_in && ctrl_word_in[BDCS_RESET_BIT]);
    COV_LOCK: cover property (@(posedge sys_clk_in) cmd[0] && cmd[1]);
    COV_FREEZE: cover property (@(posedge sys_clk_in) !clk_en_in && ctrl_wr_in);
endmodule

//--- hdl/bdcs_pkg.sv
// package for the bridge driver control and status bank
package bdcs_pkg;
    localparam int BDCS_WORD_W = 24;
    localparam int BDCS_STAGES = 17;
    localparam int BDCS_STAGE_LSB = 1;
    localparam int BDCS_BRIDGES = 6;
    localparam int BDCS_NOERR_BIT = 0;
    localparam int BDCS_DUTY_BIT = 21;
    localparam int BDCS_RESET_BIT = 22;
    localparam logic [23:0] BDCS_CTRL_RST = 24'h000000;
    localparam logic [16:0] BDCS_FLAG_RST = 17'h00000;
    // recovery timing in cycles: period and on times for 12 % and 25 % duty
    localparam int BDCS_REC_PERIOD_NS = 1000;
    localparam int BDCS_REC_PERIOD_CYC = BDCS_REC_PERIOD_NS / 10;
    localparam logic [7:0] BDCS_REC_PERIOD = 8'(BDCS_REC_PERIOD_CYC);
    localparam logic [7:0] BDCS_REC_ON_12 = 8'(BDCS_REC_PERIOD_CYC * 12 / 100);
    localparam logic [7:0] BDCS_REC_ON_25 = 8'(BDCS_REC_PERIOD_CYC * 25 / 100);

    typedef struct packed {
        logic [23:0] ctrl;
        logic [16:0] flag;
        logic [16:0] rec_act;
        logic [7:0] rec_cnt;
        logic [16:0] drive;
        logic noerr;
    } bdcs_state_t;
endpackage

//--- verification/bdcs_host.sv
// host model that writes control words to the bank
`timescale 1ns/100ps
module bdcs_host (
    // clock
    input wire logic sys_clk_in,
    // control word write
    output logic ctrl_wr_out,
    output logic [23:0] ctrl_word_out
);
    initial begin
        ctrl_wr_out = 1'b0;
        ctrl_word_out = 24'h000000;
    end
    // one word per frame, strobe held one cycle, data inverted after release,
    // then one cycle so the registered answer has settled
    task automatic send(input logic [23:0] w);
        @(posedge sys_clk_in) #1;
        ctrl_wr_out = 1'b1;
        ctrl_word_out = w;
        @(posedge sys_clk_in) #1;
        ctrl_wr_out = 1'b0;
        ctrl_word_out = ~w;
        @(posedge sys_clk_in) #1;
    endtask
    task automatic clear(input logic [23:0] w);
        send(w | 24'h400000);
    endtask
endmodule

//--- verification/tb_top.sv
// testbench for the control and status bank
`timescale 1ns/100ps
module tb_top;
    import bdcs_pkg::*;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, mod_a = 1'b0, tmode = 1'b0, ctrl_wr, sdo;
    logic clk_en = 1'b1, mod_b = 1'b0, sdi = 1'b1;
    logic [16:0] mod_sel = 17'h00000;
    logic [23:0] ctrl_word, status;
    logic [16:0] mod_en = 17'h00000, rec_en = 17'h00000, oc = 17'h00000, stage_on;
    logic [21:0] st1 = 22'h000000;
    logic [7:0] tsig = 8'h20;
    int n_fail = 0, tests_run = 0, cyc = 0, k;
    bdcs_host h (.sys_clk_in(sys_clk_in), .ctrl_wr_out(ctrl_wr), .ctrl_word_out(ctrl_word));
    bdcs_bank i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en), .ctrl_wr_in(ctrl_wr),
        .ctrl_word_in(ctrl_word), .mod_en_in(mod_en), .mod_sel_b_in(mod_sel), .modulation_input_a_in(mod_a),
        .modulation_input_b_in(mod_b), .rec_en_in(rec_en), .oc_event_in(oc), .status1_flags_in(st1),
        .test_mode_in(tmode), .test_sig_in(tsig), .serial_data_in(sdi), .stage_on_out(stage_on),
        .status_word_out(status), .serial_data_out(sdo));
    // clock and cycle ceiling
    always #5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic trip();
        oc = 17'h00002;
        @(posedge sys_clk_in) #1;
        oc = 17'h00000;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk_in);
        #1 rst_n_in = 1'b1;
        chk(status, 24'h000001);
        h.send(24'h03eaaa);
        chk({7'h00, stage_on}, 24'h01f555);
        h.send(24'h03fffe);
        chk({7'h00, stage_on}, 24'h01f000);
        $display("test switching done");
        mod_en = 17'h00002;
        h.send(24'h000004);
        chk({7'h00, stage_on}, 24'h000000);
        mod_a = 1'b1;
        @(posedge sys_clk_in) #1;
        @(posedge sys_clk_in) #1;
        chk({7'h00, stage_on}, 24'h000002);
        mod_en = 17'h00000;
        $display("test modulation done");
        trip();
        @(posedge sys_clk_in) #1;
        chk({7'h00, stage_on}, 24'h000000);
        chk(status, 24'h000004);
        repeat (120) @(posedge sys_clk_in);
        #1 chk({7'h00, stage_on}, 24'h000000);
        h.clear(24'h000004);
        chk(status, 24'h000001);
        chk({7'h00, stage_on}, 24'h000002);
        $display("test latched trip done");
        rec_en = 17'h00002;
        trip();
        k = 0;
        repeat (200) @(posedge sys_clk_in) #1 k += int'(stage_on[1]);
        chk(status, 24'h000004);
        chk({23'h000000, k >= int'(BDCS_REC_ON_12) && k <= 2 * int'(BDCS_REC_ON_12)}, 24'h000001);
        rec_en = 17'h00000;
        repeat (120) @(posedge sys_clk_in);
        h.clear(24'h000004);
        st1 = 22'h200000;
        @(posedge sys_clk_in) #1;
        @(posedge sys_clk_in) #1;
        chk(status, 24'h000000);
        st1 = 22'h000000;
        $display("test recovery done");
        chk({23'h000000, sdo}, 24'h000001);
        tmode = 1'b1;
        h.send(24'h00000a);
        chk({23'h000000, sdo}, 24'h000001);
        tsig = 8'hdf;
        #1 chk({23'h000000, sdo}, 24'h000000);
        tmode = 1'b0;
        sdi = 1'b0;
        #1 chk({23'h000000, sdo}, 24'h000000);
        sdi = 1'b1;
        $display("test mode done");
        mod_en = 17'h00001;
        mod_sel = 17'h00001;
        mod_b = 1'b0;
        @(posedge sys_clk_in) #1;
        @(posedge sys_clk_in) #1;
        chk({7'h00, stage_on}, 24'h000004);
        mod_b = 1'b1;
        @(posedge sys_clk_in) #1;
        @(posedge sys_clk_in) #1;
        chk({7'h00, stage_on}, 24'h000005);
        mod_en = 17'h00000;
        mod_sel = 17'h00000;
        $display("test second modulation input done");
        clk_en = 1'b0;
        h.send(24'h000000);
        chk({7'h00, stage_on}, 24'h000005);
        clk_en = 1'b1;
        h.send(24'h000000);
        chk({7'h00, stage_on}, 24'h000000);
        $display("test freeze done");
        tally_and_finish();
    end
endmodule
